// >>> design/gms_pkg.sv
// Package for the gateway mode sequencer: modes, command bytes, timing.
// Assumes a 50 MHz system clock and byte-wide serial command input.
package gms_pkg;
   localparam int unsigned CLK_HZ = 50_000_000;
   localparam logic [7:0] CMD_FW_REQ = 8'h06;
   localparam logic [7:0] ANS_YES = 8'h4A;
   localparam logic [7:0] ANS_NO = 8'h4E;
   localparam logic [7:0] QUERY_CHAR = 8'h3F;
   localparam logic [31:0] FIXED_IP = 32'h0A0A0A0A;
   localparam int unsigned UART_MAX_BAUD = 625_000;
   localparam logic [15:0] UART_MIN_DIV = 16'(CLK_HZ / UART_MAX_BAUD);
   localparam logic [15:0] UART_DIV_RST = 16'h01B2;
   localparam int unsigned SELFTEST_CYC = 16;
   localparam int unsigned RESTART_CYC = 8;
   localparam int unsigned LINK_PROBE_CYC = 64;
   typedef enum logic [2:0] {
      GMS_MODE_DATA = 3'h0,
      GMS_MODE_CONFIG = 3'h1,
      GMS_MODE_FWUPD = 3'h2,
      GMS_MODE_DEBUG = 3'h3
   } gms_mode_t;
   typedef enum logic [1:0] {
      GMS_SPD_NONE = 2'h0,
      GMS_SPD_10 = 2'h1,
      GMS_SPD_100 = 2'h2
   } gms_speed_t;
endpackage

// >>> design/gms_fw_if.sv
// Carrier between the sequencer and its firmware-update guard.
// Assumes a single clock domain shared by both ends.
`timescale 1ns/100ps
`default_nettype none
interface gms_fw_if;
   logic start;
   logic data_valid;
   logic [31:0] dest_ip;
   logic accepted;
   logic busy;
   logic old_invalid;
   modport seq (output start, output data_valid, output dest_ip,
      input accepted, input busy, input old_invalid);
   modport guard (input start, input data_valid, input dest_ip,
      output accepted, output busy, output old_invalid);
endinterface
`default_nettype wire

// >>> design/gms_fw_guard.sv
// Firmware replacement guard: address filter and irreversible progress flag.
// Assumes the sequencer presents the address valid for the current mode.
`timescale 1ns/100ps
`default_nettype none
module gms_fw_guard (
   input wire logic clk,
   input wire logic rst,
   input wire logic [31:0] own_ip,
   input wire logic fw_mode,
   gms_fw_if.guard fw
);
   logic busy_reg;
   logic inval_reg;
   logic acc_reg;
   logic [31:0] want_ip;
   // R5: fixed address in update mode, else R6: own address
   assign want_ip = fw_mode ? gms_pkg::FIXED_IP : own_ip;
   always_ff @(posedge clk) begin
      if (rst) begin
         acc_reg <= 1'b0;
      end else begin
         acc_reg <= fw.data_valid && (fw.dest_ip == want_ip);
      end
   end
   // R7: no abort path once started; old image stays invalid
   always_ff @(posedge clk) begin
      if (rst) begin
         busy_reg <= 1'b0;
         inval_reg <= 1'b0;
      end else if (fw.start && (fw.dest_ip == want_ip)) begin
         busy_reg <= 1'b1;
         inval_reg <= 1'b1;
      end
   end
   assign fw.accepted = acc_reg;
   assign fw.busy = busy_reg;
   assign fw.old_invalid = inval_reg;
endmodule // gms_fw_guard
`default_nettype wire

// >>> design/gms_link_det.sv
// Network link rate detector: classifies link pulse spacing as 10 or 100.
// Assumes PULSE is a one-cycle strobe per received link symbol group.
`timescale 1ns/100ps
`default_nettype none
module gms_link_det #(
   parameter int unsigned THRESH = gms_pkg::LINK_PROBE_CYC
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic pulse,
   output gms_pkg::gms_speed_t speed
);
   logic [7:0] gap_reg;
   gms_pkg::gms_speed_t speed_reg;
   // R11: automatic rate choice from pulse spacing
   always_ff @(posedge clk) begin
      if (rst) begin
         gap_reg <= 8'h00;
         speed_reg <= gms_pkg::GMS_SPD_NONE;
      end else if (pulse) begin
         gap_reg <= 8'h00;
         speed_reg <= (gap_reg < 8'(THRESH)) ? gms_pkg::GMS_SPD_100 : gms_pkg::GMS_SPD_10;
      end else if (gap_reg != 8'hFF) begin
         gap_reg <= gap_reg + 8'h01;
      end else begin
         speed_reg <= gms_pkg::GMS_SPD_NONE;
      end
   end
   assign speed = speed_reg;
endmodule // gms_link_det
`default_nettype wire

// >>> design/gms_sequencer.sv
// Gateway mode sequencer: picks the operating mode and runs the
// update confirmation dialogue on the configuration port.
// Assumes bytes arrive as one-cycle strobes, all inputs synchronous to CLK.
//
// Notes on behaviour
// R1: Boot strap held low through power-up starts the device in update mode.
// R2: In configuration mode byte 0x06 requests update mode and sends a query.
// R3: Host answers J or N; only these two bytes decide.
// R4: Yes answer restarts the device into update mode.
// R5: Update mode accepts the update only at address 10.10.10.10.
// R6: Data exchange and configuration modes accept updates at own address.
// R7: A started replacement cannot be aborted; the old image is invalid.
// R8: Configuration mode begins with a self-test; commands only after a pass.
// R9: Data exchange mode runs script and drives the network side.
// R10: Serial rate divisor is script-set, never faster than 625 Kbaud.
// R11: Network side auto-detects 10 or 100 MBaud.
// R12: Data exchange mode whenever not configuration, update or debug.
// R13: A no answer keeps configuration mode without restart.
`timescale 1ns/100ps
`default_nettype none
module gms_sequencer #(
   parameter int unsigned SELFTEST_CYC = gms_pkg::SELFTEST_CYC,
   parameter int unsigned RESTART_CYC = gms_pkg::RESTART_CYC
) (
   input wire logic CLK,
   input wire logic RST,
   input wire logic BOOT_STRAP_N,
   input wire logic CONFIG_REQ_N,
   input wire logic DEBUG_REQ,
   input wire logic [7:0] RX_DATA,
   input wire logic RX_VALID,
   input wire logic SELFTEST_OK,
   input wire logic SCRIPT_DIV_WR,
   input wire logic [15:0] SCRIPT_DIV,
   input wire logic [31:0] OWN_IP,
   input wire logic FW_START,
   input wire logic FW_DATA_VALID,
   input wire logic [31:0] FW_DEST_IP,
   input wire logic LINK_PULSE,
   output gms_pkg::gms_mode_t MODE,
   output logic [7:0] TX_DATA,
   output logic TX_VALID,
   output logic CMD_READY,
   output logic SELFTEST_FAIL,
   output logic SCRIPT_RUN,
   output logic BUS_ACTIVE,
   output logic [15:0] UART_DIV,
   output logic FW_ACCEPT,
   output logic FW_BUSY,
   output logic FW_OLD_INVALID,
   output logic [1:0] LINK_SPEED
);
   typedef enum {
      S_BOOT,
      S_SELFTEST,
      S_CMD_WAIT,
      S_CONFIRM,
      S_RESTART,
      S_RUN,
      S_FAIL
   } gms_state_t;

   gms_state_t state_reg;
   gms_pkg::gms_mode_t mode_reg;
   gms_pkg::gms_speed_t speed_w;
   logic [7:0] cnt_reg;
   logic fw_restart_reg;
   logic [7:0] tx_data_reg;
   logic tx_valid_reg;
   logic cmd_ready_reg;
   logic fail_reg;
   logic script_reg;
   logic bus_reg;
   logic [15:0] div_reg;
   logic acc_reg;
   logic busy_reg;
   logic inval_reg;
   logic [1:0] speed_reg;

   gms_fw_if fw_bus ();

   assign fw_bus.start = FW_START;
   assign fw_bus.data_valid = FW_DATA_VALID;
   assign fw_bus.dest_ip = FW_DEST_IP;

   gms_fw_guard u_guard (
      .clk(CLK),
      .rst(RST),
      .own_ip(OWN_IP),
      .fw_mode(mode_reg == gms_pkg::GMS_MODE_FWUPD),
      .fw(fw_bus.guard)
   );

   gms_link_det u_link (
      .clk(CLK),
      .rst(RST),
      .pulse(LINK_PULSE),
      .speed(speed_w)
   );

   // Strap is sampled on the first clocked step after reset, never under it
   always_ff @(posedge CLK) begin
      if (RST) begin
         state_reg <= S_BOOT;
         mode_reg <= gms_pkg::GMS_MODE_DATA;
         cnt_reg <= 8'h00;
         fw_restart_reg <= 1'b0;
      end else begin
         unique case (state_reg)
            S_BOOT: begin
               cnt_reg <= 8'h00;
               // R1: strap low forces update mode
               if (!BOOT_STRAP_N || fw_restart_reg) begin
                  mode_reg <= gms_pkg::GMS_MODE_FWUPD;
                  state_reg <= S_RUN;
               end else if (!CONFIG_REQ_N) begin
                  mode_reg <= gms_pkg::GMS_MODE_CONFIG;
                  state_reg <= S_SELFTEST;
               end else if (DEBUG_REQ) begin
                  mode_reg <= gms_pkg::GMS_MODE_DEBUG;
                  state_reg <= S_RUN;
               end else begin
                  // R12: data exchange is the default mode
                  mode_reg <= gms_pkg::GMS_MODE_DATA;
                  state_reg <= S_RUN;
               end
               fw_restart_reg <= 1'b0;
            end
            S_SELFTEST: begin
               // R8: self-test time before judging the result
               if (cnt_reg == 8'(SELFTEST_CYC - 1)) begin
                  cnt_reg <= 8'h00;
                  state_reg <= SELFTEST_OK ? S_CMD_WAIT : S_FAIL;
               end else begin
                  cnt_reg <= cnt_reg + 8'h01;
               end
            end
            S_CMD_WAIT: begin
               // R2: update request byte opens the query
               if (RX_VALID && RX_DATA == gms_pkg::CMD_FW_REQ) begin
                  state_reg <= S_CONFIRM;
               end
            end
            S_CONFIRM: begin
               // R3: only J or N decide; anything else is ignored
               if (RX_VALID && RX_DATA == gms_pkg::ANS_YES) begin
                  state_reg <= S_RESTART;
                  cnt_reg <= 8'h00;
               // R13: no keeps configuration mode, no restart
               end else if (RX_VALID && RX_DATA == gms_pkg::ANS_NO) begin
                  state_reg <= S_CMD_WAIT;
               end
            end
            S_RESTART: begin
               // R4: restart lands in update mode
               if (cnt_reg == 8'(RESTART_CYC - 1)) begin
                  fw_restart_reg <= 1'b1;
                  state_reg <= S_BOOT;
               end else begin
                  cnt_reg <= cnt_reg + 8'h01;
               end
            end
            S_RUN: begin
               state_reg <= S_RUN;
            end
            S_FAIL: begin
               state_reg <= S_FAIL;
            end
         endcase
      end
   end

   // R2: query character sent once on entering confirmation
   always_ff @(posedge CLK) begin
      if (RST) begin
         tx_data_reg <= 8'h00;
         tx_valid_reg <= 1'b0;
      end else begin
         tx_valid_reg <= (state_reg == S_CMD_WAIT) && RX_VALID
            && (RX_DATA == gms_pkg::CMD_FW_REQ);
         tx_data_reg <= gms_pkg::QUERY_CHAR;
      end
   end

   // R8: commands accepted only after a passed self-test
   always_ff @(posedge CLK) begin
      if (RST) begin
         cmd_ready_reg <= 1'b0;
         fail_reg <= 1'b0;
      end else begin
         cmd_ready_reg <= (state_reg == S_CMD_WAIT);
         fail_reg <= (state_reg == S_FAIL);
      end
   end

   // R9: script and bus active only in data exchange
   always_ff @(posedge CLK) begin
      if (RST) begin
         script_reg <= 1'b0;
         bus_reg <= 1'b0;
      end else begin
         script_reg <= (state_reg == S_RUN) && (mode_reg == gms_pkg::GMS_MODE_DATA);
         bus_reg <= (state_reg == S_RUN) && (mode_reg == gms_pkg::GMS_MODE_DATA);
      end
   end

   // R10: divisor clamped so the rate never exceeds the ceiling
   always_ff @(posedge CLK) begin
      if (RST) begin
         div_reg <= gms_pkg::UART_DIV_RST;
      end else if (SCRIPT_DIV_WR) begin
         div_reg <= (SCRIPT_DIV < gms_pkg::UART_MIN_DIV) ? gms_pkg::UART_MIN_DIV : SCRIPT_DIV;
      end
   end

   // R6: update accept passed in data, config and update modes, not debug; start and busy are not gated
   always_ff @(posedge CLK) begin
      if (RST) begin
         acc_reg <= 1'b0;
         busy_reg <= 1'b0;
         inval_reg <= 1'b0;
         speed_reg <= 2'h0;
      end else begin
         acc_reg <= fw_bus.accepted && (mode_reg != gms_pkg::GMS_MODE_DEBUG);
         busy_reg <= fw_bus.busy;
         inval_reg <= fw_bus.old_invalid;
         speed_reg <= speed_w;
      end
   end

   assign MODE = mode_reg;
   assign TX_DATA = tx_data_reg;
   assign TX_VALID = tx_valid_reg;
   assign CMD_READY = cmd_ready_reg;
   assign SELFTEST_FAIL = fail_reg;
   assign SCRIPT_RUN = script_reg;
   assign BUS_ACTIVE = bus_reg;
   assign UART_DIV = div_reg;
   assign FW_ACCEPT = acc_reg;
   assign FW_BUSY = busy_reg;
   assign FW_OLD_INVALID = inval_reg;
   assign LINK_SPEED = speed_reg;
endmodule // gms_sequencer
`default_nettype wire

// >>> verification/gms_seq_asserts.sv
// Checker for the gateway mode sequencer, watching its top-level ports.
// Assumes one clock domain and the synchronous active-high reset.
`timescale 1ns/100ps
`default_nettype none
module gms_seq_asserts #(
   parameter int unsigned SELFTEST_CYC = gms_pkg::SELFTEST_CYC,
   parameter int unsigned RESTART_CYC = gms_pkg::RESTART_CYC
) (
   input wire logic CLK,
   input wire logic RST,
   input wire logic [7:0] RX_DATA,
   input wire logic RX_VALID,
   input wire logic [31:0] OWN_IP,
   input wire logic FW_START,
   input wire logic FW_DATA_VALID,
   input wire logic [31:0] FW_DEST_IP,
   input wire gms_pkg::gms_mode_t MODE,
   input wire logic [7:0] TX_DATA,
   input wire logic TX_VALID,
   input wire logic CMD_READY,
   input wire logic SELFTEST_FAIL,
   input wire logic SCRIPT_RUN,
   input wire logic BUS_ACTIVE,
   input wire logic [15:0] UART_DIV,
   input wire logic FW_ACCEPT,
   input wire logic FW_BUSY,
   input wire logic FW_OLD_INVALID
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (RST);
   localparam int YES_MIN = RESTART_CYC;
   localparam int YES_MAX = RESTART_CYC + 30;
   logic asked_reg;
   logic [7:0] up_cnt_reg;
   // A query is open from its strobe until a decisive answer byte
   // An answer in the strobe's own cycle already decides, so closing wins
   always_ff @(posedge CLK) begin
      if (RST)
         asked_reg <= 1'b0;
      else if (RX_VALID && (RX_DATA == gms_pkg::ANS_YES || RX_DATA == gms_pkg::ANS_NO))
         asked_reg <= 1'b0;
      else if (TX_VALID)
         asked_reg <= 1'b1;
   end
   always_ff @(posedge CLK) begin
      if (RST)
         up_cnt_reg <= 8'h00;
      else if (up_cnt_reg != 8'hFF)
         up_cnt_reg <= up_cnt_reg + 8'h01;
   end
   sequence s_fw_req;
      MODE == gms_pkg::GMS_MODE_CONFIG && CMD_READY && !asked_reg && !TX_VALID
         && RX_VALID && RX_DATA == gms_pkg::CMD_FW_REQ;
   endsequence
   sequence s_answer(logic [7:0] ch);
      (asked_reg || TX_VALID) && RX_VALID && RX_DATA == ch;
   endsequence
   chk_query_reply: assert property (s_fw_req |=> TX_VALID && TX_DATA == gms_pkg::QUERY_CHAR)
      else $error("query missing after update request");
   chk_tx_cause: assert property (TX_VALID |-> $past(RX_VALID)
      && $past(RX_DATA) == gms_pkg::CMD_FW_REQ) else $error("query without request");
   chk_yes_restart: assert property (s_answer(gms_pkg::ANS_YES)
      |-> ##[YES_MIN:YES_MAX] MODE == gms_pkg::GMS_MODE_FWUPD) else $error("no restart on yes");
   chk_no_stays: assert property (s_answer(gms_pkg::ANS_NO)
      |-> ##2 (MODE == gms_pkg::GMS_MODE_CONFIG && CMD_READY) [*4])
      else $error("no answer left config");
   chk_selftest_gap: assert property (CMD_READY
      |-> up_cnt_reg >= 8'(SELFTEST_CYC + 2) && !SELFTEST_FAIL) else $error("ready before self-test");
   chk_fw_sticky: assert property (FW_BUSY |=> FW_BUSY && FW_OLD_INVALID)
      else $error("update progress dropped");
   chk_fw_start: assert property (FW_START && MODE == gms_pkg::GMS_MODE_DATA
      && FW_DEST_IP == OWN_IP |-> ##2 FW_BUSY && FW_OLD_INVALID) else $error("update start lost");
   chk_accept_cause: assert property (FW_ACCEPT |-> $past(FW_DATA_VALID, 2)
      && $past(FW_DEST_IP, 2) == (MODE == gms_pkg::GMS_MODE_FWUPD ? gms_pkg::FIXED_IP : OWN_IP))
      else $error("accept at wrong address");
   chk_div_floor: assert property (UART_DIV >= gms_pkg::UART_MIN_DIV)
      else $error("serial divisor too fast");
   chk_data_run: assert property ((MODE == gms_pkg::GMS_MODE_DATA) [*6]
      |-> SCRIPT_RUN && BUS_ACTIVE) else $error("data mode idle");
endmodule // gms_seq_asserts
bind gms_sequencer gms_seq_asserts #(.SELFTEST_CYC(SELFTEST_CYC), .RESTART_CYC(RESTART_CYC))
   u_chk (.*);
`default_nettype wire

// >>> verification/gms_host_model.sv
// Host on the configuration port: sends a command, answers the query.
// Assumes the bench pulses go for one cycle at a falling edge.
`timescale 1ns/100ps
`default_nettype none
module gms_host_model (
   input wire logic clk,
   input wire logic go,
   input wire logic [7:0] cmd,
   input wire logic [7:0] answer,
   input wire logic [1:0] lag,
   input wire logic [7:0] dev_tx,
   input wire logic dev_tx_valid,
   output logic [7:0] host_byte,
   output logic host_valid,
   output logic got_query
);
   task automatic send(logic [7:0] b);
      host_byte = b;
      host_valid = 1'b1;
      @(negedge clk);
      host_valid = 1'b0;
      // Idle line shows the inverse so a stale byte never looks valid
      host_byte = ~b;
   endtask
   initial begin
      host_byte = 8'h00;
      host_valid = 1'b0;
      got_query = 1'b0;
      forever begin
         @(posedge clk iff go);
         @(negedge clk);
         got_query = 1'b0;
         send(cmd);
         for (int i = 0; i < 8 && !got_query; i++) begin
            if (dev_tx_valid && dev_tx === gms_pkg::QUERY_CHAR)
               got_query = 1'b1;
            else
               @(negedge clk);
         end
         // At least one edge passes so the strobe drops before the answer
         repeat (lag + 1) @(negedge clk);
         if (got_query)
            send(answer);
      end
   end
endmodule // gms_host_model
`default_nettype wire

// >>> verification/tb.sv
// Self-checking bench for the gateway mode sequencer.
// Assumes the host model drives the configuration port.
`timescale 1ns/100ps
`default_nettype none
module tb;
   localparam int ST = 4;
   localparam int RS = 2;
   logic CLK, RST, BOOT_STRAP_N, CONFIG_REQ_N, DEBUG_REQ, RX_VALID, SELFTEST_OK, go, got_q;
   logic SCRIPT_DIV_WR, FW_START, FW_DATA_VALID, LINK_PULSE, TX_VALID, CMD_READY;
   logic SELFTEST_FAIL, SCRIPT_RUN, BUS_ACTIVE, FW_ACCEPT, FW_BUSY, FW_OLD_INVALID;
   logic [7:0] RX_DATA, TX_DATA, h_cmd, h_ans;
   logic [15:0] SCRIPT_DIV, UART_DIV;
   logic [31:0] OWN_IP, FW_DEST_IP;
   logic [1:0] LINK_SPEED, h_lag;
   gms_pkg::gms_mode_t MODE;
   int fails, n_checks;
   gms_sequencer #(.SELFTEST_CYC(ST), .RESTART_CYC(RS)) uut (.*);
   gms_host_model host (.clk(CLK), .go(go), .cmd(h_cmd), .answer(h_ans), .lag(h_lag),
      .dev_tx(TX_DATA), .dev_tx_valid(TX_VALID), .host_byte(RX_DATA), .host_valid(RX_VALID),
      .got_query(got_q));
   task automatic cyc(int n);
      repeat (n) @(negedge CLK);
   endtask
   task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fails++;
         $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
      end
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   function automatic gms_pkg::gms_mode_t exp_mode(logic [2:0] s);
      if (!s[2])
         return gms_pkg::GMS_MODE_FWUPD;
      if (!s[1])
         return gms_pkg::GMS_MODE_CONFIG;
      return s[0] ? gms_pkg::GMS_MODE_DEBUG : gms_pkg::GMS_MODE_DATA;
   endfunction
   function automatic logic acc_ok(gms_pkg::gms_mode_t m, logic [31:0] ip);
      if (m == gms_pkg::GMS_MODE_FWUPD)
         return ip == gms_pkg::FIXED_IP;
      return m != gms_pkg::GMS_MODE_DEBUG && ip == OWN_IP;
   endfunction
   // Written divisor, or the smallest one whose rate stays at or below the serial ceiling
   function automatic logic [15:0] exp_div(logic [15:0] d);
      if (64'(d) * 64'(gms_pkg::UART_MAX_BAUD) >= 64'(gms_pkg::CLK_HZ))
         return d;
      return 16'(gms_pkg::CLK_HZ / gms_pkg::UART_MAX_BAUD);
   endfunction
   // straps stay put through and after reset, as at power-up
   task automatic boot(logic [2:0] s);
      {BOOT_STRAP_N, CONFIG_REQ_N, DEBUG_REQ} = s;
      RST = 1'b1;
      cyc(2);
      RST = 1'b0;
      cyc(ST + 6);
   endtask
   task automatic fw_try(gms_pkg::gms_mode_t m, logic [31:0] ip);
      FW_DEST_IP = ip;
      FW_DATA_VALID = 1'b1;
      cyc(1);
      FW_DATA_VALID = 1'b0;
      FW_DEST_IP = ~ip;
      // Accept pulse stands only in the second cycle after the address
      cyc(1);
      check("fw_accept", FW_ACCEPT, acc_ok(m, ip));
   endtask
   task automatic dlg(logic [7:0] c, logic [7:0] a);
      h_cmd = c;
      h_ans = a;
      h_lag = 2'($urandom_range(0, 3));
      go = 1'b1;
      cyc(1);
      go = 1'b0;
      cyc(16);
   endtask
   task automatic pulse(int gap);
      LINK_PULSE = 1'b1;
      cyc(1);
      LINK_PULSE = 1'b0;
      cyc(gap);
   endtask
   initial begin
      CLK = 1'b0;
      forever #10 CLK = ~CLK;
   end
   initial begin
      {RST, SELFTEST_OK, go, SCRIPT_DIV_WR, FW_START, FW_DATA_VALID, LINK_PULSE} = 7'h60;
      {BOOT_STRAP_N, CONFIG_REQ_N, DEBUG_REQ, h_cmd, h_ans, h_lag} = {3'h6, 18'h0};
      {SCRIPT_DIV, FW_DEST_IP} = 48'h0;
      fails = 0;
      n_checks = 0;
      void'($urandom(32'h1F4E));
      OWN_IP = {8'hC0, 24'($urandom)};
      for (int s = 0; s < 8; s++) begin
         boot(3'(s));
         check("mode", MODE, exp_mode(3'(s)));
         fw_try(exp_mode(3'(s)), OWN_IP);
         fw_try(exp_mode(3'(s)), gms_pkg::FIXED_IP);
      end
      $display("test straps done");
      boot(3'h6);
      check("run", {SCRIPT_RUN, BUS_ACTIVE}, 2'h3);
      for (int k = 0; k < 8; k++) begin
         // Corners two below and one at the floor, then random
         SCRIPT_DIV = (k < 3) ? 16'h004E + 16'(k) : 16'($urandom_range(0, 65535));
         SCRIPT_DIV_WR = 1'b1;
         cyc(1);
         SCRIPT_DIV_WR = 1'b0;
         cyc(2);
         check("uart_div", UART_DIV, exp_div(SCRIPT_DIV));
      end
      for (int k = 0; k < 2; k++) begin
         repeat (6) pulse(k ? $urandom_range(80, 120) : $urandom_range(4, 40));
         check("link_speed", LINK_SPEED, k ? 2'h1 : 2'h2);
      end
      cyc(300);
      check("link_speed", LINK_SPEED, 2'h0);
      FW_DEST_IP = OWN_IP;
      FW_START = 1'b1;
      cyc(1);
      FW_START = 1'b0;
      cyc(30);
      check("fw_lock", {FW_BUSY, FW_OLD_INVALID}, 2'h3);
      $display("test data mode done");
      SELFTEST_OK = 1'b0;
      boot(3'h5);
      check("self_test", {SELFTEST_FAIL, CMD_READY}, 2'h2);
      dlg(gms_pkg::CMD_FW_REQ, gms_pkg::ANS_NO);
      check("query", got_q, 1'b0);
      SELFTEST_OK = 1'b1;
      boot(3'h5);
      check("self_test", {SELFTEST_FAIL, CMD_READY}, 2'h1);
      dlg(8'h41, gms_pkg::ANS_NO);
      check("query", got_q, 1'b0);
      dlg(gms_pkg::CMD_FW_REQ, gms_pkg::ANS_NO);
      check("query", got_q, 1'b1);
      check("mode", {MODE, CMD_READY}, {gms_pkg::GMS_MODE_CONFIG, 1'b1});
      dlg(gms_pkg::CMD_FW_REQ, 8'h59);
      check("mode", MODE, gms_pkg::GMS_MODE_CONFIG);
      dlg(gms_pkg::ANS_YES, gms_pkg::ANS_NO);
      for (int i = 0; MODE !== gms_pkg::GMS_MODE_FWUPD; i++) begin
         if (i == 40) begin
            fails++;
            final_report();
         end
         cyc(1);
      end
      check("mode", MODE, gms_pkg::GMS_MODE_FWUPD);
      boot(3'h6);
      dlg(gms_pkg::CMD_FW_REQ, gms_pkg::ANS_YES);
      check("query", {got_q, MODE}, {1'b0, gms_pkg::GMS_MODE_DATA});
      $display("test dialogue done");
      final_report();
   end
endmodule // tb
`default_nettype wire
